/* File: design/cml_prog_port.v */
// code memory program, verify, signature read and lock logic
//
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "cml_map.vh"
// Behaviour
// - 8k code, 64 encryption, 4 signature bytes
// - encryption bytes reset to all ones
// - six address lines pick encryption byte
// - verify data is code xnor key
// - level one: no lock restriction
// - level two: block table reads, latch ea
// - level two up refuses code programming
// - level three also disables verify
// - level four also disables external execution
// - address on ports one/two, data port0
// - setup: reset high, store strobe low
// - lock bits selected by mode pins
// - verify mode, data output enable pin
// - signature read without programming supply
// - no direct encryption read path
// - erase sets code and encryption bytes back to ones and clears the lock bits
module cml_prog_port #(
	parameter CODE_DEPTH = 8192,
	parameter ENC_DEPTH  = 64,
	parameter [31:0] SIG_WORD = 32'h11223344 // arbitrary identity value
) (
	input  wire        mclk_i,
	input  wire        sys_rst_i,
	input  wire [7:0]  port1_i,
	input  wire [4:0]  port2_addr_i,
	input  wire [7:0]  port0_i,
	output reg  [7:0]  port0_o,
	output reg         port0_oe_o,
	input  wire        rst_pin_i,
	input  wire        program_store_strobe_i,
	input  wire        program_strobe_pin_i,
	input  wire        vpp_high_i,
	input  wire        external_access_n_i,
	input  wire        mode_select_first_i,
	input  wire        mode_select_data_out_enable_i,
	input  wire        mode_select_third_i,
	input  wire        mode_select_fourth_i,
	input  wire        mode_select_fifth_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         table_read_block_o,
	output reg         ext_exec_block_o,
	output reg         ea_latched_o
);
	wire [7:0]  p0_s;
	wire [12:0] adr_s;
	wire [4:0]  mode_s;
	wire        rst_s;
	wire        pss_s;
	wire        prog_s;
	wire        vpp_s;
	wire        ean_s;

	cml_sync2 #(.W(8)) u_sd (
		.mclk_i   (mclk_i),
		.sys_rst_i(sys_rst_i),
		.d_i      (port0_i),
		.q_o      (p0_s)
	);
	cml_sync2 #(.W(13)) u_sa (
		.mclk_i   (mclk_i),
		.sys_rst_i(sys_rst_i),
		.d_i      ({port2_addr_i, port1_i}),
		.q_o      (adr_s)
	);
	cml_sync2 #(.W(10)) u_sc (
		.mclk_i   (mclk_i),
		.sys_rst_i(sys_rst_i),
		.d_i      ({mode_select_first_i, mode_select_data_out_enable_i,
			mode_select_third_i, mode_select_fourth_i,
			mode_select_fifth_i, rst_pin_i, program_store_strobe_i,
			program_strobe_pin_i, vpp_high_i, external_access_n_i}),
		.q_o      ({mode_s, rst_s, pss_s, prog_s, vpp_s, ean_s})
	);

	reg [7:0] code_mem [0:CODE_DEPTH-1];
	reg [7:0] enc_mem  [0:ENC_DEPTH-1];
	reg       lb1_q;
	reg       lb2_q;
	reg       lb3_q;
	reg       prog_dly_q;
	reg       rst_dly_q;
	reg [3:0] ctrl_q;
	reg [1:0] sig_adr_q;
	reg       erase_pend_q;
	integer   i;

	wire setup   = rst_s & ~pss_s;
	// strobe is active low; one falling edge writes one byte
	wire pulse   = prog_dly_q & ~prog_s;
	wire wr_ok   = setup & vpp_s & pulse;
	wire lvl2    = lb1_q | lb2_q | lb3_q;
	wire lvl3    = lb2_q | lb3_q;
	wire [5:0] kidx = adr_s[5:0];
	wire [7:0] vdat = ~(code_mem[adr_s] ^ enc_mem[kidx]);
	wire verify_m = setup & ~vpp_s & ~mode_s[4] & ~mode_s[2]
		& mode_s[1] & mode_s[0];
	wire sig_m   = setup & ~vpp_s & ~mode_s[4] & ~mode_s[2]
		& ~mode_s[1] & ~mode_s[0];
	wire oe_pin  = mode_s[3] == 1'b0; // data out enabled while low
	// signature locations 30h,31h,60h,61h map to index by bits 6 and 0
	wire [1:0] sidx = {adr_s[6], adr_s[0]};
	wire [7:0] sdat = SIG_WORD[8*sidx +: 8];

	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			// matches the synchroniser's reset level: no false edge
			prog_dly_q <= 1'b0;
			rst_dly_q  <= 1'b0;
		end else begin
			prog_dly_q <= prog_s;
			rst_dly_q  <= rst_s;
		end
	end

	// storage has no reset: contents persist like the array cells
	always @(posedge mclk_i) begin
		if (erase_pend_q) begin
			for (i = 0; i < CODE_DEPTH; i = i + 1)
				code_mem[i] <= `CML_ERASED_BYTE;
			for (i = 0; i < ENC_DEPTH; i = i + 1)
				enc_mem[i] <= `CML_ERASED_BYTE;
		end else if (wr_ok) begin
			if (mode_s == `CML_MODE_PROG_CODE && !lvl2)
				code_mem[adr_s] <= p0_s;
			if (mode_s == `CML_MODE_PROG_ENC)
				enc_mem[kidx] <= p0_s;
		end
	end

	initial begin
		for (i = 0; i < CODE_DEPTH; i = i + 1)
			code_mem[i] = `CML_ERASED_BYTE;
		for (i = 0; i < ENC_DEPTH; i = i + 1)
			enc_mem[i] = `CML_ERASED_BYTE;
	end

	// lock bits survive system reset; only erase clears them
	initial begin
		lb1_q = 1'b0;
		lb2_q = 1'b0;
		lb3_q = 1'b0;
	end
	always @(posedge mclk_i) begin
		if (erase_pend_q) begin
			lb1_q <= 1'b0;
			lb2_q <= 1'b0;
			lb3_q <= 1'b0;
		end else if (wr_ok) begin
			if (mode_s == `CML_MODE_PROG_LB1)
				lb1_q <= 1'b1;
			if (mode_s == `CML_MODE_PROG_LB2)
				lb2_q <= 1'b1;
			if (mode_s == `CML_MODE_PROG_LB3)
				lb3_q <= 1'b1;
		end
	end

	// verify is the only view of the key array: no bus path to it
	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			port0_o    <= 8'h00;
			port0_oe_o <= 1'b0;
		end else if (verify_m && !lvl3 && oe_pin) begin
			port0_o    <= vdat;
			port0_oe_o <= 1'b1;
		end else if (sig_m && oe_pin) begin
			port0_o    <= sdat;
			port0_oe_o <= 1'b1;
		end else begin
			port0_o    <= 8'h00;
			port0_oe_o <= 1'b0;
		end
	end

	// at lock level two and up, ea is captured at the falling edge of the reset pin
	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ea_latched_o       <= 1'b0;
			table_read_block_o <= 1'b0;
			ext_exec_block_o   <= 1'b0;
		end else begin
			if (rst_dly_q && !rst_s && lvl2)
				ea_latched_o <= ~ean_s;
			table_read_block_o <= lvl2 & ctrl_q[`CML_CTRL_TABLE_EXT];
			ext_exec_block_o   <= lb3_q & ctrl_q[`CML_CTRL_CORE_EXT];
		end
	end

	// wishbone slave: answers one cycle after the request
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			wb_ack_o     <= 1'b0;
			wb_dat_o     <= 32'h0;
			ctrl_q       <= 4'h0;
			sig_adr_q    <= 2'h0;
			erase_pend_q <= 1'b0;
		end else begin
			wb_ack_o     <= req;
			erase_pend_q <= 1'b0;
			wb_dat_o     <= 32'h0;
			if (req && wb_we_i && wb_sel_i[0]) begin
				case (wb_adr_i)
				`CML_REG_CTRL: begin
					ctrl_q       <= {1'b0, wb_dat_i[2:1], 1'b0};
					erase_pend_q <= wb_dat_i[`CML_CTRL_ERASE];
				end
				`CML_REG_SIG_ADDR: sig_adr_q <= wb_dat_i[1:0];
				default: ;
				endcase
			end else if (req && !wb_we_i) begin
				case (wb_adr_i)
				`CML_REG_CTRL:     wb_dat_o <= {28'h0, ctrl_q};
				`CML_REG_STATUS:   wb_dat_o <= {26'h0, ea_latched_o,
					verify_m, lb3_q, lb2_q, lb1_q, setup};
				`CML_REG_SIG_ADDR: wb_dat_o <= {30'h0, sig_adr_q};
				`CML_REG_SIG_DATA: wb_dat_o <= {24'h0,
					SIG_WORD[8*sig_adr_q +: 8]};
				default:           wb_dat_o <= 32'h0;
				endcase
			end
		end
	end
endmodule // cml_prog_port

/* File: design/cml_sync2.v */
// two-flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module cml_sync2 #(
	parameter W = 1
) (
	input  wire         mclk_i,
	input  wire         sys_rst_i,
	input  wire [W-1:0] d_i,
	output reg  [W-1:0] q_o
);
	reg [W-1:0] meta_q;
	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			meta_q <= {W{1'b0}};
			q_o    <= {W{1'b0}};
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule // cml_sync2

/* File: inc/cml_map.vh */
// address map, mode codes and reset values of the code memory programming port
`ifndef CML_MAP_VH
`define CML_MAP_VH
`define CML_CODE_AW        13
`define CML_ENC_AW         6
`define CML_SIG_AW         2
`define CML_ERASED_BYTE    8'hff
// mode pins packed as {first, data_out_en, third, fourth, fifth}
`define CML_MODE_PROG_CODE 5'h0f
`define CML_MODE_PROG_ENC  5'h0d
`define CML_MODE_PROG_LB1  5'h1f
`define CML_MODE_PROG_LB2  5'h1c
`define CML_MODE_PROG_LB3  5'h16
`define CML_MODE_READ_SIG  5'h00
// wishbone offsets
`define CML_REG_CTRL       8'h00
`define CML_REG_STATUS     8'h04
`define CML_REG_SIG_ADDR   8'h08
`define CML_REG_SIG_DATA   8'h0c
// ctrl fields
`define CML_CTRL_ERASE     0
`define CML_CTRL_CORE_EXT  1
`define CML_CTRL_TABLE_EXT 2
`endif

/* File: testbench/cml_prog_port_assertions.sv */
// checker on the pins and bus of the programming port
`timescale 1ns/1ps
module cml_chk (
	input wire       mclk_i,
	input wire       sys_rst_i,
	input wire [7:0] port1_i,
	input wire [4:0] port2_addr_i,
	input wire [7:0] port0_o,
	input wire       port0_oe_o,
	input wire       rst_pin_i,
	input wire       program_store_strobe_i,
	input wire       program_strobe_pin_i,
	input wire       vpp_high_i,
	input wire       mode_select_first_i,
	input wire       mode_select_data_out_enable_i,
	input wire       mode_select_third_i,
	input wire       mode_select_fourth_i,
	input wire       mode_select_fifth_i,
	input wire       wb_cyc_i,
	input wire       wb_stb_i,
	input wire       wb_ack_o,
	input wire       table_read_block_o,
	input wire       ext_exec_block_o,
	input wire       ea_latched_o
);
	wire [20:0] pins = {port1_i, port2_addr_i, rst_pin_i, vpp_high_i,
		program_strobe_pin_i, mode_select_first_i,
		mode_select_data_out_enable_i, mode_select_third_i,
		mode_select_fourth_i, mode_select_fifth_i};
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	AST_RST_QUIET: assert property ($fell(sys_rst_i) |-> !wb_ack_o &&
		!port0_oe_o && !ea_latched_o && !ext_exec_block_o)
		else $error("output busy after reset");
	AST_ACK_RESP: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("no ack");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	AST_SETUP_OFF: assert property (!rst_pin_i [*4] |=> !port0_oe_o)
		else $error("drive outside setup");
	AST_STORE_OFF: assert property (program_store_strobe_i [*4]
		|=> !port0_oe_o) else $error("drive with store strobe high");
	AST_DOE_OFF: assert property (mode_select_data_out_enable_i [*4]
		|=> !port0_oe_o) else $error("drive with output disabled");
	AST_DATA_STANDS: assert property ($stable(pins) [*5]
		|-> $stable(port0_o) && $stable(port0_oe_o))
		else $error("data moved with pins held");
	cover property (port0_oe_o && !mode_select_fourth_i);
	cover property (table_read_block_o);
	cover property (ext_exec_block_o);
endmodule // cml_chk
bind cml_prog_port cml_chk i_chk (.*);

/* File: testbench/cml_programmer.sv */
// pin-level model of the external programmer
`timescale 1ns/1ps
module cml_programmer (
	input  wire         mclk_i,
	output logic [12:0] addr_o,
	output logic [7:0]  data_o,
	output logic [4:0]  mode_o,
	output logic        vpp_o,
	output logic        strobe_n_o,
	output logic        setup_o,
	output logic        program_store_strobe_o,
	output logic        ea_n_o
);
	initial begin
		{addr_o, data_o, vpp_o, program_store_strobe_o, ea_n_o} = '0;
		mode_o = 5'h1f;
		strobe_n_o = 1;
		setup_o = 1;
	end
	task w3;
		repeat (3) @(posedge mclk_i);
	endtask
	task pins(input [4:0] m, input [12:0] a, input [7:0] d);
		@(posedge mclk_i);
		mode_o <= m;
		addr_o <= a;
		data_o <= d;
		w3;
	endtask
	// one strobe per byte, always inside a raised supply
	task burn(input [4:0] m, input [12:0] a, input [7:0] d);
		pins(m, a, d);
		vpp_o <= 1;
		w3;
		strobe_n_o <= 0;
		w3;
		strobe_n_o <= 1;
		w3;
		vpp_o <= 0;
		data_o <= ~d;
		w3;
	endtask
	task leave(input ea_n);
		@(posedge mclk_i);
		ea_n_o <= ea_n;
		setup_o <= 0;
		program_store_strobe_o <= 1;
		repeat (6) @(posedge mclk_i);
		setup_o <= 1;
		program_store_strobe_o <= 0;
		w3;
	endtask
endmodule // cml_programmer

/* File: testbench/tb_code_memory_program_verify_lock.sv */
// testbench of the programming port
`timescale 1ns/1ps
`include "cml_map.vh"
module tb_code_memory_program_verify_lock;
	logic        mclk_i = 0, sys_rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0;
	logic        wb_we_i = 0;
	logic [7:0]  wb_adr_i = 0, code [8192], key [64];
	logic [31:0] wb_dat_i = 0, q;
	logic [12:0] a, aq [$];
	int          bad_count = 0, checked = 0, lvl = 1;
	wire  [7:0]  port1_i, port0_o, prg_d, p0_in;
	wire  [4:0]  port2_addr_i;
	wire  [31:0] wb_dat_o;
	wire  [3:0]  wb_sel_i = 4'hf;
	wire         port0_oe_o, rst_pin_i, program_store_strobe_i, wb_ack_o;
	wire         program_strobe_pin_i, vpp_high_i, external_access_n_i;
	wire         mode_select_first_i, mode_select_data_out_enable_i;
	wire         mode_select_third_i, mode_select_fourth_i;
	wire         mode_select_fifth_i, table_read_block_o;
	wire         ext_exec_block_o, ea_latched_o;
	assign p0_in = port0_oe_o ? port0_o : prg_d;
	cml_prog_port i_dut (.*, .port0_i(p0_in));
	cml_programmer i_prg (.mclk_i(mclk_i),
		.addr_o({port2_addr_i, port1_i}), .data_o(prg_d),
		.mode_o({mode_select_first_i, mode_select_data_out_enable_i,
		mode_select_third_i, mode_select_fourth_i, mode_select_fifth_i}),
		.vpp_o(vpp_high_i), .strobe_n_o(program_strobe_pin_i),
		.setup_o(rst_pin_i), .program_store_strobe_o(program_store_strobe_i),
		.ea_n_o(external_access_n_i));
	initial forever #50 mclk_i = ~mclk_i;
	task chk(input logic [7:0] s, e, input string nm);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask
	task wb(input [7:0] ad, input w, input [31:0] d);
		@(posedge mclk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
		wb_adr_i <= ad;
		wb_dat_i <= d;
		do
			@(posedge mclk_i);
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
	endtask
	task prog(input [4:0] m, input [12:0] ad, input [7:0] d);
		i_prg.burn(m, ad, d);
		if (m == `CML_MODE_PROG_CODE && lvl < 2) code[ad] = d;
		if (m == `CML_MODE_PROG_ENC) key[ad[5:0]] = d;
		if (m == `CML_MODE_PROG_LB1 && lvl < 2) lvl = 2;
		if (m == `CML_MODE_PROG_LB2 && lvl < 3) lvl = 3;
		if (m == `CML_MODE_PROG_LB3) lvl = 4;
	endtask
	task vfy(input [12:0] ad);
		i_prg.pins(5'h03, ad, ~prg_d);
		repeat (4) @(posedge mclk_i);
		chk(port0_oe_o, lvl < 3, "drive");
		if (lvl < 3) chk(port0_o, ~(code[ad] ^ key[ad[5:0]]), "vd");
	endtask
	task report_and_stop;
		if (bad_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#2000000;
		bad_count++;
		report_and_stop;
	end
	initial begin
		void'($urandom(93));
		foreach (code[i]) code[i] = 8'hff;
		foreach (key[i]) key[i] = 8'hff;
		repeat (8) @(posedge mclk_i);
		sys_rst_i <= 0;
		for (int i = 0; i < 4; i++) vfy(13'($urandom));
		wb(`CML_REG_CTRL, 1, 32'h4);
		i_prg.leave(0);
		chk(table_read_block_o, 0, "table");
		chk(ea_latched_o, 0, "ea");
		for (int i = 0; i < 16; i++) begin
			a = 13'(i * 64 + $urandom % 64);
			aq.push_back(a);
			prog(`CML_MODE_PROG_CODE, a, 8'($urandom));
			vfy(a);
		end
		for (int i = 0; i < 6; i++)
			prog(`CML_MODE_PROG_ENC, i == 5 ? 63 : i * 13, 8'($urandom));
		foreach (aq[i]) vfy(aq[i]);
		for (int i = 0; i < 8; i++) vfy(13'h1fff - 13'(i * 67));
		a = 13'($urandom);
		i_prg.pins(`CML_MODE_READ_SIG, a, 8'h00);
		repeat (4) @(posedge mclk_i);
		chk(port0_oe_o, 1, "sig");
		wb(`CML_REG_SIG_ADDR, 1, {30'h0, a[6], a[0]});
		wb(`CML_REG_SIG_DATA, 0, 0);
		chk(port0_o, q[7:0], "sig data");
		i_prg.pins(5'h08, 0, 8'h00);
		repeat (4) @(posedge mclk_i);
		chk(port0_oe_o, 0, "sig doe");
		prog(`CML_MODE_PROG_LB1, 0, 0);
		wb(`CML_REG_STATUS, 0, 0);
		chk(q[3:1], 3'h1, "locks");
		chk(table_read_block_o, 1, "table");
		i_prg.leave(0);
		chk(ea_latched_o, 1, "ea");
		prog(`CML_MODE_PROG_CODE, aq[0], 8'h00);
		vfy(aq[0]);
		wb(8'h10, 0, 0);
		chk(q[7:0], 0, "unmapped");
		prog(`CML_MODE_PROG_LB2, 0, 0);
		vfy(aq[1]);
		wb(`CML_REG_CTRL, 1, 32'h6);
		chk(ext_exec_block_o, 0, "ext");
		prog(`CML_MODE_PROG_LB3, 0, 0);
		chk(ext_exec_block_o, 1, "ext");
		wb(`CML_REG_CTRL, 1, 32'h5);
		foreach (code[i]) code[i] = 8'hff;
		foreach (key[i]) key[i] = 8'hff;
		lvl = 1;
		repeat (4) @(posedge mclk_i);
		chk(table_read_block_o, 0, "table");
		for (int i = 0; i < 3; i++) vfy(aq[i]);
		report_and_stop;
	end
endmodule // tb_code_memory_program_verify_lock
